// ### src/crc_engine_map.vh
// Register map, field layout and constants of the CRC engine.
// Assumes inclusion by the CRC engine top module only.
`ifndef CRC_ENGINE_MAP_VH
`define CRC_ENGINE_MAP_VH

// Byte addresses of the word registers
`define ADDR_CRC_CONTROL 8'h00
`define ADDR_INPUT_BYTE 8'h04
`define ADDR_AUTO_SCAN 8'h08
`define ADDR_SECTOR_COUNT 8'h0c
`define ADDR_RESULT_BYTE 8'h10
`define ADDR_STATUS 8'h14

// Control register fields
`define CTL_WIDTH_BIT 4
`define CTL_INIT_BIT 3
`define CTL_PRESET_BIT 2
`define CTL_PTR_HI 1
`define CTL_PTR_LO 0

// Auto scan control fields
`define AUTO_EN_BIT 7
`define AUTO_PAGE_HI 5
`define AUTO_PAGE_LO 0

// Polynomials and presets
`define POLY32 32'h04c11db7
`define POLY16 16'h1021
`define PRESET_ONES 32'hffffffff
`define PRESET_ZEROS 32'h00000000
`define PRESET_ONES16 16'hffff

// Sector geometry and flash address width
`define SECTOR_BYTES_LOG2 9
`define SECTOR_LAST 9'h1ff
`define SECTOR_FIRST 9'h000
`define CNT_NONE 8'h00
`define CNT_ONE 8'h01
`define FLASH_ADDR_W 15
`define HTRANS_NONSEQ 2'b10
`define HSIZE_WORD 3'b010

`endif

// ### src/crc_engine.v
// CRC engine with byte-wide software feed and automatic flash sector scan.
// Assumes an AHB-Lite master as sole bus master and a flash read port with one-cycle latency.
//
// Behaviour
// - Width bit selects 32-bit or 16-bit polynomial
// - Preset bit selects zeros or ones preset
// - Init trigger write outside a scan loads preset into result
// - Each input byte write outside a scan updates result
// - Auto scan feeds 512 bytes per sector
// - Any control write outside a scan starts enabled auto scan if the sector count is nonzero
// - Processor stall held during whole scan
// - Result is 32 or 16 bits wide
// - Result port accesses pointed byte, pointer increments
// - Result holds until init, overwrite or update
// - Pointer byte mapping, wrapping in 16-bit mode
// - Control layout bits 4..0, bits 7:5 zero
`timescale 1ns/1ps
`default_nettype none
`include "crc_engine_map.vh"

module crc_engine (
	// Clock and reset
	input wire sys_clk,
	input wire srst,
	// AHB-Lite slave
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	// Processor stall during auto scan
	output reg cpu_stall,
	// Flash read port
	output reg flash_rd,
	output reg [14:0] flash_addr,
	input wire [7:0] flash_data
);

	// Sequencer states of the flash scan
	localparam ST_IDLE = 2'b00;
	localparam ST_READ = 2'b01;
	localparam ST_FEED = 2'b10;

	// One MSB-first CRC step over a byte, 32 or 16 bits wide
	// No reflection and no final inversion
	function [31:0] crc_byte;
		input [31:0] crc;
		input [7:0] data;
		input narrow;
		integer i;
		reg [31:0] c;
		begin
			c = crc;
			// Eight shifts, data bit 7 first
			for (i = 7; i >= 0; i = i - 1) begin
				if (narrow) begin
					// Upper half stays clear in 16-bit width
					if (c[15] ^ data[i]) begin
						c = {16'h0000, c[14:0], 1'b0} ^ {16'h0000, `POLY16};
					end else begin
						c = {16'h0000, c[14:0], 1'b0};
					end
				end else begin
					if (c[31] ^ data[i]) begin
						c = {c[30:0], 1'b0} ^ `POLY32;
					end else begin
						c = {c[30:0], 1'b0};
					end
				end
			end
			crc_byte = c;
		end
	endfunction

	// Byte lane of the result chosen by pointer and width
	function [1:0] lane;
		input [1:0] ptr;
		input narrow;
		begin
			lane = narrow ? {1'b0, ptr[0]} : ptr;
		end
	endfunction

	// Preset loaded on an init write, cut to the active width
	// Keeps the unused upper half clear in 16-bit width
	function [31:0] preset_value;
		input ones;
		input narrow;
		begin
			if (!ones) begin
				preset_value = `PRESET_ZEROS;
			end else if (narrow) begin
				preset_value = {16'h0000, `PRESET_ONES16};
			end else begin
				preset_value = `PRESET_ONES;
			end
		end
	endfunction

	// Address match, shared by write strobes and read mux
	function hit;
		input [7:0] addr;
		input [7:0] target;
		begin
			hit = (addr == target);
		end
	endfunction

	// Configuration fields
	reg width_sel;
	reg preset_sel;
	reg [1:0] byte_ptr;
	reg auto_en;
	reg [5:0] start_page;
	reg [7:0] sector_cnt;

	// Result, its next value and the read mux output
	reg [31:0] result;
	reg [31:0] next_result;
	reg [31:0] rd_word;

	// Scan sequencer
	reg [1:0] state;
	reg [8:0] byte_idx;
	reg [7:0] sectors_left;

	// Registered address phase
	reg dp_valid;
	reg dp_write;
	reg [7:0] dp_addr;

	// Bus decode of the address and data phases
	wire addr_phase = hsel && hready && (htrans == `HTRANS_NONSEQ);
	wire rd_phase = addr_phase && !hwrite;
	wire wr_ctl = dp_valid && dp_write && hit(dp_addr, `ADDR_CRC_CONTROL);
	wire wr_in = dp_valid && dp_write && hit(dp_addr, `ADDR_INPUT_BYTE);
	wire wr_auto = dp_valid && dp_write && hit(dp_addr, `ADDR_AUTO_SCAN);
	wire wr_cnt = dp_valid && dp_write && hit(dp_addr, `ADDR_SECTOR_COUNT);
	wire acc_res = dp_valid && hit(dp_addr, `ADDR_RESULT_BYTE);
	wire wr_res = acc_res && dp_write;

	// Byte lane, CRC steps and scan conditions for the current cycle
	wire [1:0] cur_lane = lane(byte_ptr, width_sel);
	wire [31:0] upd_in = crc_byte(result, hwdata[7:0], width_sel);
	wire [31:0] upd_fl = crc_byte(result, flash_data, width_sel);
	wire [31:0] preset_wr = preset_value(hwdata[`CTL_PRESET_BIT], hwdata[`CTL_WIDTH_BIT]);
	wire scan_start = wr_ctl && auto_en && (state == ST_IDLE);
	wire scan_go = scan_start && (sector_cnt != `CNT_NONE);
	wire last_byte = (byte_idx == `SECTOR_LAST) && (sectors_left == `CNT_ONE);

	// Register values as they stand once the current data phase ends
	// A read right behind a write sees the written value
	wire next_width = wr_ctl ? hwdata[`CTL_WIDTH_BIT] : width_sel;
	wire next_preset = wr_ctl ? hwdata[`CTL_PRESET_BIT] : preset_sel;
	wire [1:0] next_ptr = wr_ctl ? hwdata[`CTL_PTR_HI:`CTL_PTR_LO] :
		(acc_res ? byte_ptr + 2'b01 : byte_ptr);
	wire [1:0] next_lane = lane(next_ptr, next_width);
	wire next_auto_en = wr_auto ? hwdata[`AUTO_EN_BIT] : auto_en;
	wire [5:0] next_page = wr_auto ? hwdata[`AUTO_PAGE_HI:`AUTO_PAGE_LO] : start_page;
	wire [7:0] next_cnt = wr_cnt ? hwdata[7:0] : sector_cnt;
	wire next_stall = scan_go ? 1'b1 :
		((state == ST_FEED && last_byte) ? 1'b0 : cpu_stall);

	// Lane bytes follow the next result value
	wire [7:0] lane_byte [0:3];
	genvar k;
	generate
		for (k = 0; k < 4; k = k + 1) begin : g_lane
			assign lane_byte[k] = next_result[8 * k +: 8];
		end
	endgenerate

	// Next result: init, software byte, byte overwrite or flash byte
	always @* begin
		next_result = result;
		if (state == ST_IDLE) begin
			// Software changes to the result are ignored while a scan runs
			if (wr_ctl && hwdata[`CTL_INIT_BIT]) begin
				next_result = preset_wr;
			end else if (wr_in) begin
				next_result = upd_in;
			end else if (wr_res) begin
				next_result[{cur_lane, 3'b000} +: 8] = hwdata[7:0];
			end
		end else if (state == ST_FEED) begin
			next_result = upd_fl;
		end
	end

	// Read mux over the register map
	always @* begin
		rd_word = 32'h00000000;
		if (hit(haddr, `ADDR_CRC_CONTROL)) begin
			// Init trigger always reads back as zero
			rd_word = {27'h0000000, next_width, 1'b0, next_preset, next_ptr};
		end else if (hit(haddr, `ADDR_INPUT_BYTE)) begin
			// Input byte port is write only
			rd_word = 32'h00000000;
		end else if (hit(haddr, `ADDR_AUTO_SCAN)) begin
			rd_word = {24'h000000, next_auto_en, 1'b0, next_page};
		end else if (hit(haddr, `ADDR_SECTOR_COUNT)) begin
			rd_word = {24'h000000, next_cnt};
		end else if (hit(haddr, `ADDR_RESULT_BYTE)) begin
			rd_word = {24'h000000, lane_byte[next_lane]};
		end else if (hit(haddr, `ADDR_STATUS)) begin
			// Status bit shows a scan in progress
			rd_word = {31'h00000000, next_stall};
		end
	end

	// Address phase capture and bus response
	// No wait states: every data phase lasts one cycle
	always @(posedge sys_clk) begin
		if (srst) begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_addr <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			if (hready) begin
				dp_valid <= addr_phase;
				dp_write <= hwrite;
				dp_addr <= haddr;
			end
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Read data latched at the address phase, stands through the data phase
	always @(posedge sys_clk) begin
		if (srst) begin
			hrdata <= 32'h00000000;
		end else if (rd_phase) begin
			hrdata <= rd_word;
		end
	end

	// Control, configuration and pointer registers
	always @(posedge sys_clk) begin
		if (srst) begin
			width_sel <= 1'b0;
			preset_sel <= 1'b0;
			byte_ptr <= 2'b00;
			auto_en <= 1'b0;
			start_page <= 6'h00;
			sector_cnt <= 8'h00;
		end else begin
			// Pointer moves on each result port access
			width_sel <= next_width;
			preset_sel <= next_preset;
			byte_ptr <= next_ptr;
			auto_en <= next_auto_en;
			start_page <= next_page;
			sector_cnt <= next_cnt;
		end
	end

	// Result and stall registers
	always @(posedge sys_clk) begin
		if (srst) begin
			result <= `PRESET_ZEROS;
			cpu_stall <= 1'b0;
		end else begin
			result <= next_result;
			cpu_stall <= next_stall;
		end
	end

	// Scan sequencer: one read cycle and one feed cycle per byte
	always @(posedge sys_clk) begin
		if (srst) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (scan_go) begin
						state <= ST_READ;
					end
				end
				ST_READ: begin
					// Flash byte arrives one cycle after the read pulse
					state <= ST_FEED;
				end
				ST_FEED: begin
					if (last_byte) begin
						state <= ST_IDLE;
					end else begin
						state <= ST_READ;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Byte and sector counters of the running scan
	always @(posedge sys_clk) begin
		if (srst) begin
			byte_idx <= `SECTOR_FIRST;
			sectors_left <= `CNT_NONE;
		end else if (scan_go) begin
			byte_idx <= `SECTOR_FIRST;
			sectors_left <= sector_cnt;
		end else if (state == ST_FEED && !last_byte) begin
			// Index wraps from a sector's last byte to the next one's first
			byte_idx <= byte_idx + 9'h001;
			if (byte_idx == `SECTOR_LAST) begin
				sectors_left <= sectors_left - `CNT_ONE;
			end
		end
	end

	// Flash read port: one pulse per byte, ascending addresses
	always @(posedge sys_clk) begin
		if (srst) begin
			flash_rd <= 1'b0;
			flash_addr <= 15'h0000;
		end else if (scan_go) begin
			flash_rd <= 1'b1;
			flash_addr <= {start_page, `SECTOR_FIRST};
		end else if (state == ST_FEED && !last_byte) begin
			flash_rd <= 1'b1;
			flash_addr <= flash_addr + 15'h0001;
		end else begin
			flash_rd <= 1'b0;
		end
	end

endmodule // crc_engine

`default_nettype wire

// ### dv/crc_engine_assertions.sv
// Port assertions for the CRC engine.
// Assumes a bind onto crc_engine; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module crc_engine_chk (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Bus answer
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Scan side
	input wire logic cpu_stall,
	input wire logic flash_rd,
	input wire logic [14:0] flash_addr
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	logic [8:0] n_byte;
	// Flash reads seen in the current scan, modulo a sector
	always @(posedge sys_clk) n_byte <= (srst || !cpu_stall) ? 9'h0 : n_byte + {8'h0, flash_rd};
	sequence byte_step;
		flash_rd ##2 flash_rd;
	endsequence
	// Last byte fed: stall drops one cycle after the feed
	sequence scan_end;
		!flash_rd ##1 !cpu_stall;
	endsequence
	chk_bus_ready: assert property (hreadyout) else $error("wait state inserted");
	chk_bus_okay: assert property (!hresp) else $error("error response");
	chk_rd_pulse: assert property (flash_rd |=> !flash_rd ##1 (flash_rd or scan_end)) else $error("read pace");
	chk_addr_step: assert property (byte_step |-> flash_addr == $past(flash_addr, 2) + 15'h1) else $error("addr");
	chk_rd_stall: assert property (flash_rd |-> cpu_stall) else $error("read without stall");
	chk_scan_start: assert property ($rose(cpu_stall) |-> flash_rd && flash_addr[8:0] == 9'h0) else $error("start");
	chk_scan_len: assert property ($fell(cpu_stall) |-> n_byte == 9'h0) else $error("partial sector");
	chk_byte_reads: assert property (hrdata[31:8] == 24'h0) else $error("upper read bits");
endmodule // crc_engine_chk
bind crc_engine crc_engine_chk chk_u(.sys_clk(sys_clk), .srst(srst), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .cpu_stall(cpu_stall), .flash_rd(flash_rd), .flash_addr(flash_addr));
`default_nettype wire

// ### dv/tb_top.sv
// Bench for the CRC engine: control, byte feed, result port, flash scan.
// Assumes a zero-wait AHB-Lite slave and a bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic sys_clk = 0, srst = 1, hsel = 0, hwrite = 0, w, p;
	logic [7:0] haddr = 0, flash_data = 0, rnd = 8'h2e;
	logic [1:0] htrans = 0;
	logic [31:0] hwdata = 0, hrdata, crc, q;
	logic hreadyout, hresp, cpu_stall, flash_rd;
	logic [14:0] flash_addr;
	int n_fail = 0, checked = 0, i;
	always #50 sys_clk = ~sys_clk;
	crc_engine dut_u(.sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.cpu_stall(cpu_stall), .flash_rd(flash_rd), .flash_addr(flash_addr), .flash_data(flash_data));
	// Flash answers after a read pulse, else shows a moving value
	always @(posedge sys_clk) flash_data <= flash_rd ? fbyte(flash_addr) : ~flash_data;
	function automatic [7:0] fbyte(input [14:0] a); return a[7:0] ^ a[14:7]; endfunction
	function automatic [7:0] nx(input [7:0] s); return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]}; endfunction
	// One byte through the CRC, MSB first
	function automatic [31:0] step(input [31:0] c, input [7:0] b, input n);
		for (int k = 7; k >= 0; k--) c = ((n ? c[15] : c[31]) ^ b[k]) ? (c << 1) ^ (n ? 32'h1021 : 32'h04c11db7) : c << 1;
		return n ? c & 32'hffff : c;
	endfunction
	task automatic end_of_test;
		$display("Checks %0d, errors %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string what, input [31:0] e, input [31:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s exp %h got %h", what, e, g);
		end
	endtask
	task automatic rdy;
		int t;
		t = 0;
		do begin @(posedge sys_clk); t++; end while (hreadyout !== 1'b1 && t < 20);
		if (hreadyout !== 1'b1) begin n_fail++; end_of_test; end
	endtask
	// Single transfer: address phase, then data phase
	task automatic bus(input [7:0] a, input wr, input [31:0] d);
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'b10;
		hsel <= 1'b1;
		rdy;
		htrans <= 2'b00;
		hwdata <= d;
		rdy;
		q = hrdata;
	endtask
	task automatic rd_res;
		for (int j = 0; j < 4; j++) begin
			bus(8'h10, 0, 0);
			chk("result", (crc >> (8 * (w ? j % 2 : j))) & 32'hff, q);
		end
	endtask
	// Main sequence over all width and preset pairs
	initial begin
		repeat (4) @(posedge sys_clk);
		srst <= 0;
		bus(8'h00, 0, 0); chk("control", 0, q);
		bus(8'h18, 0, 0); chk("unmapped", 0, q);
		for (int m = 0; m < 4; m++) begin
			w = m[1];
			p = m[0];
			bus(8'h00, 1, {27'h7, w, 1'b0, p, 2'b00});
			bus(8'h00, 1, {27'h7, w, 1'b1, p, 2'b00});
			bus(8'h00, 0, 0); chk("control", {w, 1'b0, p, 2'b00}, q);
			crc = p ? (w ? 32'hffff : 32'hffffffff) : 0;
			for (i = 0; i < 3 + m; i++) begin
				rnd = nx(rnd);
				bus(8'h04, 1, rnd);
				crc = step(crc, rnd, w);
			end
			rd_res;
			bus(8'h10, 1, rnd);
			crc[7:0] = rnd;
			bus(8'h00, 1, {w, 1'b0, p, 2'b00});
			bus(8'h10, 0, 0); chk("rewrite", crc & 32'hff, q);
			bus(8'h08, 1, rnd[4:0]);
			bus(8'h08, 1, 8'h80 | rnd[4:0]);
			bus(8'h0c, 1, m[0] + 1);
			bus(8'h08, 0, 0); chk("auto", 8'h80 | rnd[4:0], q);
			bus(8'h0c, 0, 0); chk("count", m[0] + 1, q);
			bus(8'h00, 1, {w, 1'b1, p, 2'b00});
			crc = p ? (w ? 32'hffff : 32'hffffffff) : 0;
			for (i = 0; i < (m[0] + 1) * 512; i++) crc = step(crc, fbyte(15'({rnd[4:0], 9'h0} + i)), w);
			@(posedge sys_clk);
			chk("stall", 1, cpu_stall);
			bus(8'h04, 1, 8'h5a);
			bus(8'h14, 0, 0); chk("status", 1, q);
			for (i = 0; cpu_stall !== 1'b0 && i < 2100; i++) @(posedge sys_clk);
			if (i >= 2100) begin n_fail++; end_of_test; end
			bus(8'h08, 1, rnd[4:0]);
			rd_res;
		end
		// Reset after the last run, then control and result read back cleared
		srst <= 1;
		repeat (2) @(posedge sys_clk);
		srst <= 0;
		w = 0;
		crc = 0;
		bus(8'h00, 0, 0); chk("reset control", 0, q);
		rd_res;
		end_of_test;
	end
endmodule // tb_top
`default_nettype wire
